// File: shared/obcfg_pkg.sv
// Option byte decoder package: constants, field layout and carrier types
package obcfg_pkg;

  // Wishbone register offsets (byte addresses)
  localparam logic [7:0] OBCFG_CTRL_OFS = 8'h00;
  localparam logic [7:0] OBCFG_STAT_OFS = 8'h04;

  // Control register fields
  localparam int OBCFG_CTRL_SWWDG_BIT = 0;

  // Status register fields
  localparam int OBCFG_STAT_BYTE0_LSB = 0;
  localparam int OBCFG_STAT_BYTE1_LSB = 8;
  localparam int OBCFG_STAT_ROM_BIT = 16;
  localparam int OBCFG_STAT_PROG_BIT = 17;
  localparam int OBCFG_STAT_DIP_BIT = 18;
  localparam int OBCFG_STAT_WDG_BIT = 19;
  localparam int OBCFG_STAT_WDGEN_BIT = 20;

  // Option byte 0 bit positions
  localparam int OBCFG_OPT_HALT_BIT = 7;
  localparam int OBCFG_OPT_WSW_BIT = 6;
  localparam int OBCFG_OPT_RSVD_BIT = 5;
  localparam int OBCFG_OPT_DIP_BIT = 4;
  localparam int OBCFG_OPT_PLL_BIT = 3;

  // Erased flash content
  localparam logic [7:0] OBCFG_ERASED = 8'hFF;

  // Reset pin drive time
  localparam int OBCFG_CLK_PERIOD_NS = 100;
  localparam int OBCFG_RST_PULSE_NS = 2000;
  localparam int OBCFG_RST_PULSE_CYC =
    (OBCFG_RST_PULSE_NS + OBCFG_CLK_PERIOD_NS - 1) / OBCFG_CLK_PERIOD_NS;

  // Programming port pins and the supply dip pin as one bundle
  typedef struct packed {
    logic mode;
    logic wr;
    logic sel;
    logic [7:0] wdata;
    logic supply_dip;
  } obcfg_pins_t;

  // Decoded option settings
  typedef struct packed {
    logic halt_entry_reset_select;
    logic watchdog_soft_enable_select;
    logic supply_dip_detect_enable;
    logic pll_enable;
  } obcfg_cfg_t;

  // Reset sequencer states
  typedef enum logic [1:0] {
    OBCFG_RS_IDLE,
    OBCFG_RS_DRIVE,
    OBCFG_RS_RELOAD
  } obcfg_rs_t;

endpackage

// File: tb/obcfg_tool.sv
// Programming tool model driving the option byte pins
`timescale 1ns/1ns
module obcfg_tool
  import obcfg_pkg::*;
(
  input wire logic i_core_clk,
  output logic o_mode,
  output logic o_wr,
  output logic o_sel,
  output logic [7:0] o_wdata
);
  // Pins idle at time zero
  initial
  begin
    o_mode = 1'b0;
    o_wr = 1'b0;
    o_sel = 1'b0;
    o_wdata = 8'hA5;
  end
  // Enter or leave programming mode
  task automatic mode(input logic m);
    @(posedge i_core_clk);
    o_mode <= m;
    @(negedge i_core_clk);
  endtask
  // One byte per strobe, data held around the strobe
  task automatic put(input logic s, input logic [7:0] b);
    @(posedge i_core_clk);
    o_sel <= s;
    o_wdata <= b | 8'h20;
    repeat (3) @(posedge i_core_clk);
    o_wr <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    o_wr <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    o_wdata <= ~o_wdata;
    @(negedge i_core_clk);
  endtask
endmodule

// File: tb/obcfg_top_asserts.sv
// Port checks for the option byte decoder
`timescale 1ns/1ns
module obcfg_top_asserts
  import obcfg_pkg::*;
#(
  parameter bit MASKED_ROM = 1'b0,
  parameter logic [7:0] ROM_BYTE0 = 8'hFF
)
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic i_halt_entry,
  input wire logic i_wdg_timeout,
  input wire logic o_wdg_enable,
  input wire logic o_halt_entry_reset_select,
  input wire logic o_watchdog_soft_enable_select,
  input wire logic o_supply_dip_detect_enable,
  input wire logic o_pll_enable,
  input wire logic o_rst_pin_oe
);
  localparam logic [7:0] B0 = MASKED_ROM ? ROM_BYTE0 : OBCFG_ERASED;
  logic [2:0] up; // Age since power reset
  logic [2:0] calm; // Age since any reset
  logic [4:0] hi; // Reset pin drive length
  logic [3:0] cfg; // Decoded options
  assign cfg = {o_halt_entry_reset_select, o_watchdog_soft_enable_select,
    o_supply_dip_detect_enable, o_pll_enable};
  // Saturating age counters and a wrapping pulse counter
  always_ff @(posedge i_core_clk)
  begin
    up <= !i_rst_n ? 3'h0 : up + 3'(up != 3'h7);
    calm <= (!i_rst_n || o_rst_pin_oe) ? 3'h0 : calm + 3'(calm != 3'h7);
    hi <= (!i_rst_n || !o_rst_pin_oe) ? 5'h00 : hi + 5'h01;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_req; i_wb_cyc && i_wb_stb && !o_wb_ack; endsequence
  sequence s_ack; o_wb_ack ##1 !o_wb_ack; endsequence
  AST_ACK_ONCE: assert property (s_req |=> s_ack)
    else $error("bus ack is not one pulse after request");
  AST_UNMAPPED_ZERO: assert property (o_wb_ack && !$past(i_wb_we) &&
    $past(i_wb_adr) != OBCFG_CTRL_OFS && $past(i_wb_adr) != OBCFG_STAT_OFS
    |-> o_wb_dat == 32'h0) else $error("unmapped read not zero");
  AST_ERASED: assert property (up == 3'h5 |->
    cfg == {B0[7], B0[6], !B0[4], !B0[3]}) else $error("start options wrong");
  AST_HW_WDG: assert property (calm == 3'h7 &&
    !o_watchdog_soft_enable_select |-> o_wdg_enable)
    else $error("hardware watchdog not running");
  AST_HALT: assert property (calm > 3'h2 && o_wdg_enable &&
    o_halt_entry_reset_select && i_halt_entry |=> o_rst_pin_oe)
    else $error("halt entry gave no reset");
  AST_TIMEOUT: assert property (calm > 3'h2 && o_wdg_enable &&
    i_wdg_timeout |=> o_rst_pin_oe) else $error("timeout gave no reset");
  AST_PULSE_LEN: assert property ($fell(o_rst_pin_oe) |->
    hi == 5'(OBCFG_RST_PULSE_CYC)) else $error("reset pin pulse length");
  AST_CFG_HELD: assert property (calm == 3'h7 && up == 3'h7 |->
    $stable(cfg)) else $error("options changed outside reset");
endmodule
bind obcfg_top obcfg_top_asserts #(.MASKED_ROM(MASKED_ROM),
  .ROM_BYTE0(ROM_BYTE0)) obcfg_top_asserts_inst (.i_core_clk(i_core_clk),
  .i_rst_n(i_rst_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat),
  .o_wb_ack(o_wb_ack), .i_halt_entry(i_halt_entry),
  .i_wdg_timeout(i_wdg_timeout), .o_wdg_enable(o_wdg_enable),
  .o_halt_entry_reset_select(o_halt_entry_reset_select),
  .o_watchdog_soft_enable_select(o_watchdog_soft_enable_select),
  .o_supply_dip_detect_enable(o_supply_dip_detect_enable),
  .o_pll_enable(o_pll_enable), .o_rst_pin_oe(o_rst_pin_oe));

// File: tb/obcfg_top_test.sv
// Self-checking bench for the option byte decoder
`timescale 1ns/1ns
`define CHK(a, e) \
  begin \
    comparisons++; \
    if ((a) !== (e)) \
    begin \
      err_total++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); \
    end \
  end
module obcfg_top_test
  import obcfg_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0; // Bus cycle and strobe together
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic halt = 1'b0;
  logic tmo = 1'b0;
  logic dip = 1'b0;
  wire [31:0] rdat;
  wire ack;
  wire [7:0] rdata;
  wire oe;
  wire pin_o; // Reset pin level while driven
  wire [5:0] rom_outs; // Masked part, same order as outs
  wire [7:0] rom_rdata; // Masked part programming readback
  wire [5:0] outs; // Halt, soft, dip, pll, watchdog, internal clock
  wire mode, wr, sel;
  wire [7:0] wd;
  logic [31:0] q; // Last read word
  int err_total = 0;
  int comparisons = 0;
  always #50 clk = ~clk;
  obcfg_top obcfg_top_inst (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(req), .i_wb_stb(req),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hF),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_prog_mode(mode), .i_prog_wr(wr),
    .i_prog_sel(sel), .i_prog_wdata(wd), .o_prog_rdata(rdata),
    .i_supply_dip(dip), .i_halt_entry(halt), .i_wdg_timeout(tmo),
    .o_wdg_enable(outs[1]), .o_halt_entry_reset_select(outs[5]),
    .o_watchdog_soft_enable_select(outs[4]),
    .o_supply_dip_detect_enable(outs[3]), .o_pll_enable(outs[2]),
    .o_int_clk_enable(outs[0]), .o_rst_pin_o(pin_o), .o_rst_pin_oe(oe));
  obcfg_tool obcfg_tool_inst (.i_core_clk(clk), .o_mode(mode), .o_wr(wr),
    .o_sel(sel), .o_wdata(wd));
  // Masked part on the same pins and bus, fixed option bytes
  obcfg_top #(.MASKED_ROM(1'b1), .ROM_BYTE0(8'h6F), .ROM_BYTE1(8'hFF))
    obcfg_top_rom_inst (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(req), .i_wb_stb(req),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hF),
    .o_wb_dat(), .o_wb_ack(), .i_prog_mode(mode), .i_prog_wr(wr),
    .i_prog_sel(sel), .i_prog_wdata(wd), .o_prog_rdata(rom_rdata),
    .i_supply_dip(dip), .i_halt_entry(halt), .i_wdg_timeout(tmo),
    .o_wdg_enable(rom_outs[1]), .o_halt_entry_reset_select(rom_outs[5]),
    .o_watchdog_soft_enable_select(rom_outs[4]),
    .o_supply_dip_detect_enable(rom_outs[3]), .o_pll_enable(rom_outs[2]),
    .o_int_clk_enable(rom_outs[0]), .o_rst_pin_o(), .o_rst_pin_oe());
  // Verdict and end of run
  task automatic results();
    if (err_total == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Give up on a hung wait
  task automatic guard(input int n);
    if (n > 99)
    begin
      err_total++;
      results();
    end
  endtask
  // One classic bus cycle, read word into q
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // Ack and data as sampled at each rising edge
    do
    begin
      @(posedge clk);
      n++;
      guard(n);
    end
    while (ack !== 1'b1);
    q = rdat;
    req <= 1'b0;
  endtask
  // Wait until reset pin drive equals v
  task automatic wt(input logic v, output int n);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
      guard(n);
    end
    while (oe !== v);
  endtask
  // Measure one reset pulse, then check its cause flags
  task automatic pulse(input logic [2:0] cause);
    int n;
    wt(1'b1, n);
    `CHK(pin_o, 1'b0);
    wt(1'b0, n);
    `CHK(n, OBCFG_RST_PULSE_CYC);
    wb(1'b0, OBCFG_STAT_OFS, 32'h0);
    `CHK(q[20:18], cause);
    @(negedge clk);
  endtask
  // Blank part, bus cannot reach bytes, soft watchdog halt reset
  task automatic t_erased();
    `CHK(outs, 6'b110001);
    `CHK(rom_outs, 6'b011000);
    wb(1'b0, OBCFG_STAT_OFS, 32'h0);
    `CHK(q[20:0], 21'h00FFFF);
    wb(1'b1, OBCFG_STAT_OFS, 32'h0);
    wb(1'b0, OBCFG_STAT_OFS, 32'h0);
    `CHK(q[15:0], 16'hFFFF);
    wb(1'b0, 8'h08, 32'h0);
    `CHK(q, 32'h0);
    wb(1'b1, OBCFG_CTRL_OFS, 32'h1);
    @(negedge clk);
    `CHK(outs[1], 1'b1);
    @(posedge clk);
    halt <= 1'b1;
    @(posedge clk);
    halt <= 1'b0;
    pulse(3'b010);
    `CHK(outs[1], 1'b0);
  endtask
  // Program both bytes, leave programming mode
  task automatic t_program();
    obcfg_tool_inst.mode(1'b1);
    obcfg_tool_inst.put(1'b0, 8'h07);
    `CHK(rdata, 8'h27);
    `CHK(rom_rdata, 8'h6F);
    obcfg_tool_inst.put(1'b1, 8'hFE);
    `CHK(rdata, 8'hFE);
    `CHK(rom_rdata, 8'hFF);
    obcfg_tool_inst.mode(1'b0);
    pulse(3'b100);
    `CHK(outs, 6'b001110);
    `CHK(rdata, 8'h00);
    `CHK(rom_outs, 6'b011000);
  endtask
  // Hardware watchdog expiry resets, options kept
  task automatic t_timeout();
    @(posedge clk);
    tmo <= 1'b1;
    @(posedge clk);
    tmo <= 1'b0;
    pulse(3'b110);
    `CHK(outs, 6'b001110);
  endtask
  // Halt entry with reset deselected
  task automatic t_halt();
    @(posedge clk);
    halt <= 1'b1;
    @(posedge clk);
    halt <= 1'b0;
    repeat (5) @(negedge clk);
    `CHK(oe, 1'b0);
  endtask
  // Supply dip with detector enabled
  task automatic t_dip();
    @(posedge clk);
    dip <= 1'b1;
    repeat (3) @(posedge clk);
    dip <= 1'b0;
    pulse(3'b101);
  endtask
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(negedge clk);
    t_erased();
    t_program();
    t_timeout();
    t_halt();
    t_dip();
    results();
  end
endmodule

// File: verilog/obcfg_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module obcfg_sync
  import obcfg_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] meta_reg; // First stage, read only by second

  // Two flops in series
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      meta_reg <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end

endmodule

// File: verilog/obcfg_top.sv
// Option byte store, decoder, reset sequencer and Wishbone status slave
`timescale 1ns/1ns
module obcfg_top
  import obcfg_pkg::*;
#(
  parameter bit MASKED_ROM = 1'b0,
  parameter logic [7:0] ROM_BYTE0 = 8'hFF,
  parameter logic [7:0] ROM_BYTE1 = 8'hFF
)
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_prog_mode,
  input wire logic i_prog_wr,
  input wire logic i_prog_sel,
  input wire logic [7:0] i_prog_wdata,
  output logic [7:0] o_prog_rdata,
  input wire logic i_supply_dip,
  input wire logic i_halt_entry,
  input wire logic i_wdg_timeout,
  output logic o_wdg_enable,
  output logic o_halt_entry_reset_select,
  output logic o_watchdog_soft_enable_select,
  output logic o_supply_dip_detect_enable,
  output logic o_pll_enable,
  output logic o_int_clk_enable,
  output logic o_rst_pin_o,
  output logic o_rst_pin_oe
);

  localparam int PIN_W = $bits(obcfg_pins_t);
  localparam int CNT_W = $clog2(OBCFG_RST_PULSE_CYC + 1);
  localparam logic [CNT_W-1:0] PULSE_LAST =
    CNT_W'(OBCFG_RST_PULSE_CYC - 1);

  // Decode one option byte 0 into settings
  function automatic obcfg_cfg_t decode(input logic [7:0] b);
    obcfg_cfg_t c;
    c.halt_entry_reset_select = b[OBCFG_OPT_HALT_BIT];
    c.watchdog_soft_enable_select = b[OBCFG_OPT_WSW_BIT];
    c.supply_dip_detect_enable = ~b[OBCFG_OPT_DIP_BIT];
    c.pll_enable = ~b[OBCFG_OPT_PLL_BIT];
    return c;
  endfunction

  obcfg_pins_t pins_raw; // Pin bundle before crossing
  obcfg_pins_t pins; // Pin bundle after crossing
  logic [7:0] store_reg [0:1]; // Flash option bytes
  logic prog_wr_d_reg; // Previous write strobe level
  logic prog_mode_d_reg; // Previous programming mode level
  obcfg_cfg_t cfg_reg; // Captured settings
  logic [7:0] byte0_reg; // Captured byte 0 image
  logic [7:0] byte1_reg; // Captured byte 1 image
  obcfg_rs_t rs_reg; // Reset sequencer state
  logic [CNT_W-1:0] cnt_reg; // Reset pin drive counter
  logic sw_wdg_reg; // Software watchdog enable
  logic cause_dip_reg; // Last reset from supply dip
  logic cause_wdg_reg; // Last reset from watchdog
  logic [7:0] src0; // Effective byte 0 source
  logic [7:0] src1; // Effective byte 1 source
  logic prog_wr_rise; // Programming write edge
  logic prog_exit; // Leaving programming mode
  logic wdg_active; // Watchdog currently running
  logic ev_dip; // Supply dip reset event
  logic ev_wdg; // Watchdog or halt reset event
  logic wb_req; // New bus request this cycle

  assign pins_raw = '{mode: i_prog_mode, wr: i_prog_wr, sel: i_prog_sel,
                      wdata: i_prog_wdata, supply_dip: i_supply_dip};

  // Cross all pin inputs into the core clock
  obcfg_sync #(.W(PIN_W)) obcfg_sync_inst
  (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_async(pins_raw),
    .o_sync(pins)
  );

  // Masked parts take fixed bytes, flash parts the store
  assign src0 = MASKED_ROM ? ROM_BYTE0 : store_reg[0];
  assign src1 = MASKED_ROM ? ROM_BYTE1 : store_reg[1];

  assign prog_wr_rise = pins.mode & pins.wr & ~prog_wr_d_reg;
  assign prog_exit = prog_mode_d_reg & ~pins.mode;

  // Hardware watchdog always runs, software one on request
  assign wdg_active = ~cfg_reg.watchdog_soft_enable_select | sw_wdg_reg;

  // Internal reset sources
  assign ev_dip = pins.supply_dip & cfg_reg.supply_dip_detect_enable;
  assign ev_wdg = wdg_active & (i_wdg_timeout |
                  (i_halt_entry & cfg_reg.halt_entry_reset_select));

  assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;

  // Edge history for programming strobes
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      prog_wr_d_reg <= 1'b0;
      prog_mode_d_reg <= 1'b0;
    end
    else
    begin
      prog_wr_d_reg <= pins.wr;
      prog_mode_d_reg <= pins.mode;
    end
  end

  // Option byte store, written only by the programming port
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      // Power-on models a blank part
      store_reg[0] <= OBCFG_ERASED;
      store_reg[1] <= OBCFG_ERASED;
    end
    else if (prog_wr_rise && !MASKED_ROM)
    begin
      // Whole byte stored as given, reserved bit included
      store_reg[pins.sel] <= pins.wdata;
    end
  end

  // Programming port readback, blank outside programming mode
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      o_prog_rdata <= 8'h00;
    else if (pins.mode)
      o_prog_rdata <= pins.sel ? src1 : src0;
    else
      o_prog_rdata <= 8'h00;
  end

  // Reset sequencer: drive pin, then recapture options
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      rs_reg <= OBCFG_RS_RELOAD;
      cnt_reg <= '0;
    end
    else
    begin
      case (rs_reg)
        OBCFG_RS_IDLE:
        begin
          // Any internal source or programming exit starts a reset
          if (ev_dip || ev_wdg || prog_exit)
          begin
            rs_reg <= OBCFG_RS_DRIVE;
            cnt_reg <= '0;
          end
        end
        OBCFG_RS_DRIVE:
        begin
          // Hold the pin low for the full pulse
          if (cnt_reg == PULSE_LAST)
            rs_reg <= OBCFG_RS_RELOAD;
          else
            cnt_reg <= cnt_reg + 1'b1;
        end
        OBCFG_RS_RELOAD:
          rs_reg <= OBCFG_RS_IDLE;
        default:
          rs_reg <= OBCFG_RS_IDLE;
      endcase
    end
  end

  // Reset pin open-drain drive, low while pulsing
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      o_rst_pin_o <= 1'b0;
      o_rst_pin_oe <= 1'b0;
    end
    else
    begin
      o_rst_pin_o <= 1'b0;
      o_rst_pin_oe <= (rs_reg == OBCFG_RS_IDLE) ?
                      (ev_dip | ev_wdg | prog_exit) :
                      (rs_reg == OBCFG_RS_DRIVE && cnt_reg != PULSE_LAST);
    end
  end

  // Capture options at end of reset, held for the session
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      cfg_reg <= decode(OBCFG_ERASED);
      byte0_reg <= OBCFG_ERASED;
      byte1_reg <= OBCFG_ERASED;
    end
    else if (rs_reg == OBCFG_RS_RELOAD)
    begin
      cfg_reg <= decode(src0);
      byte0_reg <= src0;
      byte1_reg <= src1;
    end
  end

  // Decoded outputs from flops
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      o_halt_entry_reset_select <= 1'b1;
      o_watchdog_soft_enable_select <= 1'b1;
      o_supply_dip_detect_enable <= 1'b0;
      o_pll_enable <= 1'b0;
      o_wdg_enable <= 1'b0;
      o_int_clk_enable <= 1'b0;
    end
    else
    begin
      o_halt_entry_reset_select <= cfg_reg.halt_entry_reset_select;
      o_watchdog_soft_enable_select <=
        cfg_reg.watchdog_soft_enable_select;
      o_supply_dip_detect_enable <= cfg_reg.supply_dip_detect_enable;
      o_pll_enable <= cfg_reg.pll_enable;
      o_wdg_enable <= wdg_active;
      // Blank flash keeps the reserved clock for in-circuit programming
      o_int_clk_enable <= !MASKED_ROM &&
                          (pins.mode || byte1_reg == OBCFG_ERASED);
    end
  end

  // Last internal reset cause, replaced at each new event
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      cause_dip_reg <= 1'b0;
      cause_wdg_reg <= 1'b0;
    end
    else if (rs_reg == OBCFG_RS_IDLE && (ev_dip || ev_wdg || prog_exit))
    begin
      cause_dip_reg <= ev_dip;
      cause_wdg_reg <= ev_wdg;
    end
  end

  // Software watchdog enable, set by bus, cleared by device reset
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      sw_wdg_reg <= 1'b0;
    else if (rs_reg == OBCFG_RS_DRIVE)
      sw_wdg_reg <= 1'b0;
    else if (wb_req && i_wb_we && i_wb_sel[0] &&
             i_wb_adr == OBCFG_CTRL_OFS)
      sw_wdg_reg <= i_wb_dat[OBCFG_CTRL_SWWDG_BIT];
  end

  // Wishbone slave: ack one cycle after request, unmapped reads zero
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end
    else
    begin
      o_wb_ack <= wb_req;
      if (wb_req && !i_wb_we)
      begin
        // Option bytes themselves have no bus address
        case (i_wb_adr)
          OBCFG_CTRL_OFS:
            o_wb_dat <= {31'h00000000, sw_wdg_reg};
          OBCFG_STAT_OFS:
          begin
            o_wb_dat <= 32'h00000000;
            o_wb_dat[OBCFG_STAT_BYTE0_LSB +: 8] <= byte0_reg;
            o_wb_dat[OBCFG_STAT_BYTE1_LSB +: 8] <= byte1_reg;
            o_wb_dat[OBCFG_STAT_ROM_BIT] <= MASKED_ROM;
            o_wb_dat[OBCFG_STAT_PROG_BIT] <= pins.mode;
            o_wb_dat[OBCFG_STAT_DIP_BIT] <= cause_dip_reg;
            o_wb_dat[OBCFG_STAT_WDG_BIT] <= cause_wdg_reg;
            o_wb_dat[OBCFG_STAT_WDGEN_BIT] <= wdg_active;
          end
          default:
            o_wb_dat <= 32'h00000000;
        endcase
      end
    end
  end

endmodule
